// file: hdl/ssi_readback_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ssi_readback_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic on_cmd,
  input wire logic readback,
  input wire logic passivated,
  input wire logic ack,
  input wire logic ack_required,
  input wire logic [31:0] timeout,
  output logic q,
  output logic error
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_q;
  logic next_error;
  logic mismatch;
  logic set_err;
  logic clr_err;

  // readback is a break contact: it must read the inverse of q
  always_comb begin
    mismatch = (readback == q) & ~passivated;
    set_err = mismatch & (cnt >= timeout);
    clr_err = ~mismatch & (ack_required ? ack : 1'b1);
    next_cnt = mismatch ? ((cnt == 32'hFFFFFFFF) ? cnt : cnt + 32'h1) : 32'h0;
    next_error = set_err | (error & ~clr_err);
    next_q = on_cmd & ~passivated & ~error & ~set_err & (q | readback);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 32'h0;
      q <= 1'b0;
      error <= 1'b0;
    end else begin
      cnt <= next_cnt;
      q <= next_q;
      error <= next_error;
    end
  end

  property p_pick_up;
    @(posedge aclk) disable iff (!aresetn)
      on_cmd && readback && !error && !passivated && !q |=> q;
  endproperty
  a_pick_up: assert property (p_pick_up) else $error("monitor failed to pick up");

  property p_timeout_err;
    @(posedge aclk) disable iff (!aresetn)
      mismatch && (cnt >= timeout) |=> error && !q;
  endproperty
  a_timeout_err: assert property (p_timeout_err) else $error("timeout did not latch");

  property p_err_held;
    @(posedge aclk) disable iff (!aresetn)
      error && ack_required && !ack |=> error;
  endproperty
  a_err_held: assert property (p_err_held) else $error("error cleared without ack");

  property p_passive_quiet;
    @(posedge aclk) disable iff (!aresetn)
      passivated && !error |=> !error;
  endproperty
  a_passive_quiet: assert property (p_passive_quiet) else $error("passivation raised error");
endmodule : ssi_readback_monitor
`default_nettype wire

// file: hdl/ssi_top.sv
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ssi_top #(
  parameter logic [31:0] STOP_DELAY_DEFAULT = 32'(ssi_pkg::STOP_DELAY_CYC),
  parameter logic [31:0] READBACK_TIMEOUT_DEFAULT = 32'(ssi_pkg::READBACK_TIMEOUT_CYC)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ssi_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ssi_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic start_input,
  input wire logic stop_input,
  input wire logic acknowledge_input,
  input wire logic emergency_button_input,
  input wire logic guard_contact_input,
  input wire logic contactor_readback_input,
  input wire logic module_passivated_flag,
  output logic drive_run_request,
  output logic line_contactor_a,
  output logic line_contactor_b,
  output logic module_reinstate_bit,
  output logic irq
);
  localparam logic constant_true_source = 1'b1;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  function automatic logic addr_mapped(input logic [ssi_pkg::ADDR_W-1:0] a);
    return (a == ssi_pkg::OFS_STOP_DELAY) || (a == ssi_pkg::OFS_READBACK_TIMEOUT) ||
           (a == ssi_pkg::OFS_STATUS) || (a == ssi_pkg::OFS_IRQ_STATUS) ||
           (a == ssi_pkg::OFS_IRQ_CLEAR) || (a == ssi_pkg::OFS_IRQ_ENABLE);
  endfunction : addr_mapped

  // safety state
  logic emergency_stop_enable;
  logic guard_door_enable;
  logic safety_side_readback_copy;
  logic ack_prev;
  logic passivated_prev;
  logic rb_error_prev;
  ssi_pkg::ssi_estop_st_t estop_st;
  logic [31:0] delay_cnt;
  logic next_emergency_stop_enable;
  logic next_guard_door_enable;
  logic next_drive_run_request;
  logic next_module_reinstate_bit;
  ssi_pkg::ssi_estop_st_t next_estop_st;
  logic [31:0] next_delay_cnt;
  logic ack_fall;
  logic guard_trip;
  logic estop_done;
  logic monitor_q;
  logic rb_error;

  // register file and bus state
  logic [31:0] stop_delay_time;
  logic [31:0] readback_timeout;
  logic [ssi_pkg::IRQ_W-1:0] irq_status;
  logic [ssi_pkg::IRQ_W-1:0] irq_enable;
  logic [31:0] next_stop_delay_time;
  logic [31:0] next_readback_timeout;
  logic [ssi_pkg::IRQ_W-1:0] next_irq_status;
  logic [ssi_pkg::IRQ_W-1:0] next_irq_enable;
  logic [ssi_pkg::IRQ_W-1:0] irq_events;
  logic next_irq;
  logic next_awready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [31:0] next_rdata;
  logic wr_fire;
  logic [31:0] status_word;

  always_comb begin
    ack_fall = ack_prev & ~acknowledge_input;
    next_estop_st = estop_st;
    next_delay_cnt = delay_cnt;
    next_emergency_stop_enable = emergency_stop_enable;
    next_guard_door_enable = guard_door_enable;
    estop_done = 1'b0;
    case (estop_st)
      ssi_pkg::SSI_ESTOP_IDLE: begin
        if (!emergency_button_input && emergency_stop_enable) begin
          next_estop_st = ssi_pkg::SSI_ESTOP_DELAY;
          next_delay_cnt = 32'h0;
        end
      end
      ssi_pkg::SSI_ESTOP_DELAY: begin
        // once started the delay runs out unless an acknowledge falls with button released and guard closed: a brief release alone must not keep power on
        if (delay_cnt >= stop_delay_time) begin
          next_emergency_stop_enable = 1'b0;
          next_estop_st = ssi_pkg::SSI_ESTOP_IDLE;
          estop_done = 1'b1;
        end else begin
          next_delay_cnt = delay_cnt + 32'h1;
        end
      end
      default: begin
        next_estop_st = ssi_pkg::SSI_ESTOP_IDLE;
      end
    endcase
    // enables leave reset low, so even the first start needs an acknowledge
    if (ack_fall && emergency_button_input && guard_contact_input) begin
      next_emergency_stop_enable = 1'b1;
      next_guard_door_enable = 1'b1;
      next_estop_st = ssi_pkg::SSI_ESTOP_IDLE;
      estop_done = 1'b0;
    end
    guard_trip = ~guard_contact_input & guard_door_enable;
    if (!guard_contact_input) begin
      next_guard_door_enable = 1'b0;
    end
    // clear has priority over start
    if (stop_input || !emergency_button_input) begin
      next_drive_run_request = 1'b0;
    end else if (start_input) begin
      next_drive_run_request = 1'b1;
    end else begin
      next_drive_run_request = drive_run_request;
    end
    // toggling while passivated gives a fresh rising edge every other cycle
    next_module_reinstate_bit = module_passivated_flag & ~module_reinstate_bit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emergency_stop_enable <= 1'b0;
      guard_door_enable <= 1'b0;
      drive_run_request <= 1'b0;
      module_reinstate_bit <= 1'b0;
      estop_st <= ssi_pkg::SSI_ESTOP_IDLE;
      delay_cnt <= 32'h0;
      ack_prev <= 1'b0;
      passivated_prev <= 1'b0;
      rb_error_prev <= 1'b0;
      safety_side_readback_copy <= 1'b1;
    end else begin
      emergency_stop_enable <= next_emergency_stop_enable;
      guard_door_enable <= next_guard_door_enable;
      drive_run_request <= next_drive_run_request;
      module_reinstate_bit <= next_module_reinstate_bit;
      estop_st <= next_estop_st;
      delay_cnt <= next_delay_cnt;
      ack_prev <= acknowledge_input;
      passivated_prev <= module_passivated_flag;
      rb_error_prev <= rb_error;
      safety_side_readback_copy <= contactor_readback_input;
    end
  end

  ssi_readback_monitor u_readback_monitor (
    .aclk(aclk),
    .aresetn(aresetn),
    .on_cmd(emergency_stop_enable & guard_door_enable),
    .readback(safety_side_readback_copy),
    .passivated(module_passivated_flag),
    .ack(acknowledge_input),
    .ack_required(constant_true_source),
    .timeout(readback_timeout),
    .q(monitor_q),
    .error(rb_error)
  );

  // one flop feeds both contactors so they can never disagree
  assign line_contactor_a = monitor_q;
  assign line_contactor_b = monitor_q;

  always_comb begin
    irq_events = '0;
    irq_events[ssi_pkg::IRQ_GUARD_TRIP] = guard_trip;
    irq_events[ssi_pkg::IRQ_ESTOP_DONE] = estop_done;
    irq_events[ssi_pkg::IRQ_RB_ERROR] = rb_error & ~rb_error_prev;
    irq_events[ssi_pkg::IRQ_PASSIVATED] = module_passivated_flag & ~passivated_prev;
    status_word = 32'h0;
    status_word[ssi_pkg::ST_ESTOP_EN] = emergency_stop_enable;
    status_word[ssi_pkg::ST_GUARD_EN] = guard_door_enable;
    status_word[ssi_pkg::ST_RUN_REQ] = drive_run_request;
    status_word[ssi_pkg::ST_CONTACTOR] = monitor_q;
    status_word[ssi_pkg::ST_RB_ERROR] = rb_error;
    status_word[ssi_pkg::ST_PASSIVATED] = module_passivated_flag;
    status_word[ssi_pkg::ST_DELAYING] = (estop_st == ssi_pkg::SSI_ESTOP_DELAY);
    wr_fire = s_axi_awready;
    next_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    next_stop_delay_time = stop_delay_time;
    next_readback_timeout = readback_timeout;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp = addr_mapped(s_axi_awaddr) ? ssi_pkg::RESP_OKAY : ssi_pkg::RESP_SLVERR;
      case (s_axi_awaddr)
        ssi_pkg::OFS_STOP_DELAY: begin
          next_stop_delay_time = merge_bytes(stop_delay_time, s_axi_wdata, s_axi_wstrb);
        end
        ssi_pkg::OFS_READBACK_TIMEOUT: begin
          next_readback_timeout = merge_bytes(readback_timeout, s_axi_wdata, s_axi_wstrb);
        end
        ssi_pkg::OFS_IRQ_CLEAR: begin
          if (s_axi_wstrb[0]) begin
            next_irq_status = irq_status & ~s_axi_wdata[ssi_pkg::IRQ_W-1:0];
          end
        end
        ssi_pkg::OFS_IRQ_ENABLE: begin
          if (s_axi_wstrb[0]) begin
            next_irq_enable = s_axi_wdata[ssi_pkg::IRQ_W-1:0];
          end
        end
        default: begin
          next_bresp = next_bresp;
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_irq_status = next_irq_status | irq_events;
    next_irq = |(next_irq_status & next_irq_enable);
    next_arready = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = addr_mapped(s_axi_araddr) ? ssi_pkg::RESP_OKAY : ssi_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        ssi_pkg::OFS_STOP_DELAY: next_rdata = stop_delay_time;
        ssi_pkg::OFS_READBACK_TIMEOUT: next_rdata = readback_timeout;
        ssi_pkg::OFS_STATUS: next_rdata = status_word;
        ssi_pkg::OFS_IRQ_STATUS: next_rdata = {28'h0, irq_status};
        ssi_pkg::OFS_IRQ_ENABLE: next_rdata = {28'h0, irq_enable};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_delay_time <= STOP_DELAY_DEFAULT;
      readback_timeout <= READBACK_TIMEOUT_DEFAULT;
      irq_status <= '0;
      irq_enable <= ssi_pkg::IRQ_ENABLE_RESET;
      irq <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ssi_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= ssi_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end else begin
      stop_delay_time <= next_stop_delay_time;
      readback_timeout <= next_readback_timeout;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      irq <= next_irq;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_awready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  property p_clear_wins;
    @(posedge aclk) disable iff (!aresetn)
      stop_input && start_input |=> !drive_run_request;
  endproperty
  a_clear_wins: assert property (p_clear_wins) else $error("start beat clear");

  property p_ack_sets;
    @(posedge aclk) disable iff (!aresetn)
      ack_prev && !acknowledge_input && emergency_button_input && guard_contact_input
      |=> emergency_stop_enable && guard_door_enable;
  endproperty
  a_ack_sets: assert property (p_ack_sets) else $error("acknowledge did not set enables");

  property p_guard_drop;
    @(posedge aclk) disable iff (!aresetn)
      !guard_contact_input |=> !guard_door_enable ##1 !line_contactor_a;
  endproperty
  a_guard_drop: assert property (p_guard_drop) else $error("guard open kept power");

  property p_estop_delay;
    @(posedge aclk) disable iff (!aresetn)
      estop_st == ssi_pkg::SSI_ESTOP_DELAY && delay_cnt < stop_delay_time && guard_contact_input
      |=> emergency_stop_enable;
  endproperty
  a_estop_delay: assert property (p_estop_delay) else $error("enable dropped early");

  property p_estop_run;
    @(posedge aclk) disable iff (!aresetn)
      !emergency_button_input |=> !drive_run_request;
  endproperty
  a_estop_run: assert property (p_estop_run) else $error("run request survived stop");

  property p_needs_ack;
    @(posedge aclk) disable iff (!aresetn)
      !line_contactor_a ##1 line_contactor_a |-> $past(emergency_stop_enable && guard_door_enable);
  endproperty
  a_needs_ack: assert property (p_needs_ack) else $error("contactor rose without enables");

  property p_pair;
    @(posedge aclk) disable iff (!aresetn)
      line_contactor_a == line_contactor_b;
  endproperty
  a_pair: assert property (p_pair) else $error("contactors disagree");

  property p_reinstate;
    @(posedge aclk) disable iff (!aresetn)
      module_passivated_flag [*2] |-> $rose(module_reinstate_bit) || $fell(module_reinstate_bit);
  endproperty
  a_reinstate: assert property (p_reinstate) else $error("no reinstate edge");

  property p_copy;
    @(posedge aclk) disable iff (!aresetn)
      ##1 safety_side_readback_copy == $past(contactor_readback_input);
  endproperty
  a_copy: assert property (p_copy) else $error("readback copy stale");
endmodule : ssi_top
`default_nettype wire

// file: pkg/ssi_pkg.sv
package ssi_pkg;
  localparam int CLK_MHZ = 250;
  localparam int STOP_DELAY_US = 1000;
  localparam int STOP_DELAY_CYC = STOP_DELAY_US * CLK_MHZ;
  localparam int READBACK_TIMEOUT_US = 100;
  localparam int READBACK_TIMEOUT_CYC = READBACK_TIMEOUT_US * CLK_MHZ;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STOP_DELAY = 8'h00;
  localparam logic [7:0] OFS_READBACK_TIMEOUT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam int ST_ESTOP_EN = 0;
  localparam int ST_GUARD_EN = 1;
  localparam int ST_RUN_REQ = 2;
  localparam int ST_CONTACTOR = 3;
  localparam int ST_RB_ERROR = 4;
  localparam int ST_PASSIVATED = 5;
  localparam int ST_DELAYING = 6;
  localparam int IRQ_W = 4;
  localparam int IRQ_GUARD_TRIP = 0;
  localparam int IRQ_ESTOP_DONE = 1;
  localparam int IRQ_RB_ERROR = 2;
  localparam int IRQ_PASSIVATED = 3;
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {SSI_ESTOP_IDLE, SSI_ESTOP_DELAY} ssi_estop_st_t;
endpackage : ssi_pkg

// file: testbench/ssi_contactor_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssi_contactor_model #(
  parameter int LAG = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic line_contactor_a,
  input wire logic line_contactor_b,
  input wire logic module_reinstate_bit,
  input wire logic weld,
  input wire logic passivate,
  output logic contactor_readback_input,
  output logic module_passivated_flag
);
  int lag_cnt;
  logic reinstate_d;
  always @(posedge aclk) begin
    reinstate_d <= module_reinstate_bit;
    if (!aresetn) begin
      contactor_readback_input <= 1'b1;
      module_passivated_flag <= 1'b0;
      lag_cnt <= 0;
    end else begin
      // break contact trails the coils by a mechanical lag; a weld freezes it
      if (!weld && contactor_readback_input == (line_contactor_a & line_contactor_b)) begin
        lag_cnt <= lag_cnt + 1;
        if (lag_cnt >= LAG) begin
          contactor_readback_input <= ~contactor_readback_input;
          lag_cnt <= 0;
        end
      end else begin
        lag_cnt <= 0;
      end
      if (passivate) begin
        module_passivated_flag <= 1'b1;
      end else if (module_reinstate_bit && !reinstate_d) begin
        module_passivated_flag <= 1'b0;
      end
    end
  end
endmodule : ssi_contactor_model
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] SD0 = 32'h14;
  localparam logic [31:0] TMO = 32'hC;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic start = 1'b0, stop = 1'b0, ack = 1'b0, estop = 1'b1, guard = 1'b1;
  logic weld = 1'b0, passivate = 1'b0;
  logic readback, passivated, run_req, con_a, con_b, reinstate, irq;
  logic [31:0] rd;
  int err_total = 0, cmp_count = 0, cyc_count = 0, n, sd, m_run;
  always #2 aclk = ~aclk;
  ssi_top #(.STOP_DELAY_DEFAULT(SD0), .READBACK_TIMEOUT_DEFAULT(32'h0A)) i_ssi_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .start_input(start), .stop_input(stop),
    .acknowledge_input(ack), .emergency_button_input(estop),
    .guard_contact_input(guard), .contactor_readback_input(readback),
    .module_passivated_flag(passivated), .drive_run_request(run_req),
    .line_contactor_a(con_a), .line_contactor_b(con_b),
    .module_reinstate_bit(reinstate), .irq(irq));
  ssi_contactor_model #(.LAG(3)) i_ssi_contactor_model (
    .aclk(aclk), .aresetn(aresetn), .line_contactor_a(con_a),
    .line_contactor_b(con_b), .module_reinstate_bit(reinstate), .weld(weld),
    .passivate(passivate), .contactor_readback_input(readback),
    .module_passivated_flag(passivated));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // ceiling is some fifty times the expected run length
  always @(posedge aclk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 20000) begin
      err_total = err_total + 1;
      finish_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  task automatic wait_con(input logic v);
    #1;
    n = 0;
    while (con_a !== v && n < 400) begin
      @(posedge aclk);
      #1;
      n++;
    end
    chk("contactor", {31'h0, con_a}, {31'h0, v});
    chk("contactor_b", {31'h0, con_b}, {31'h0, v});
  endtask : wait_con
  task automatic ack_pulse();
    @(posedge aclk);
    ack <= 1'b1;
    @(posedge aclk);
    ack <= 1'b0;
  endtask : ack_pulse
  task automatic status_bit(input int b, input logic v);
    axi_read(ssi_pkg::OFS_STATUS);
    chk("status", {31'h0, rd[b]}, {31'h0, v});
  endtask : status_bit
  initial begin
    void'($urandom(32'h1520));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("reset_out", {28'h0, run_req, con_a, con_b, irq}, 32'h0);
    axi_read(ssi_pkg::OFS_STOP_DELAY);
    chk("stop_delay_reset", rd, SD0);
    // stop delay must outlast the rundown of the motor
    sd = 16 + ($urandom % 16);
    axi_write(ssi_pkg::OFS_STOP_DELAY, sd);
    axi_read(ssi_pkg::OFS_STOP_DELAY);
    chk("stop_delay", rd, sd);
    axi_write(ssi_pkg::OFS_READBACK_TIMEOUT, TMO);
    // only lane 0 may land: upper lanes keep the old timeout bytes
    s_axi_wstrb <= 4'h1;
    axi_write(ssi_pkg::OFS_READBACK_TIMEOUT, 32'hAAAAAA0D);
    s_axi_wstrb <= 4'hF;
    axi_read(ssi_pkg::OFS_READBACK_TIMEOUT);
    chk("strobe_lanes", rd, {TMO[31:8], 8'h0D});
    axi_write(ssi_pkg::OFS_READBACK_TIMEOUT, TMO);
    axi_read(8'h40);
    chk("unmapped_rd", {rd[29:0], rsp}, {30'h0, ssi_pkg::RESP_SLVERR});
    axi_write(8'h40, 32'h1);
    chk("unmapped_wr", {30'h0, rsp}, {30'h0, ssi_pkg::RESP_SLVERR});
    axi_write(ssi_pkg::OFS_IRQ_ENABLE, 32'hF);
    $display("test registers done");
    for (int i = 0; i < 24; i++) begin
      @(posedge aclk);
      start <= 1'($urandom);
      stop <= 1'($urandom);
      @(posedge aclk);
      #1;
      m_run = (stop == 1'b1) ? 0 : ((start == 1'b1) ? 1 : m_run);
      chk("run_request", {31'h0, run_req}, m_run);
    end
    @(posedge aclk);
    start <= 1'b1;
    stop <= 1'b0;
    repeat (10) @(posedge aclk);
    #1;
    chk("no_ack_contactor", {31'h0, con_a}, 32'h0);
    ack_pulse();
    wait_con(1'b1);
    chk("ack_latency", {31'h0, n <= 4}, 32'h1);
    repeat (20) @(posedge aclk);
    status_bit(ssi_pkg::ST_RB_ERROR, 1'b0);
    $display("test acknowledge done");
    axi_write(ssi_pkg::OFS_IRQ_CLEAR, 32'hF);
    @(posedge aclk);
    guard <= 1'b0;
    wait_con(1'b0);
    chk("guard_latency", {31'h0, n <= 2}, 32'h1);
    repeat (3) @(posedge aclk);
    #1;
    chk("irq_set", {31'h0, irq}, 32'h1);
    axi_read(ssi_pkg::OFS_IRQ_STATUS);
    chk("irq_guard", {31'h0, rd[ssi_pkg::IRQ_GUARD_TRIP]}, 32'h1);
    axi_write(ssi_pkg::OFS_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge aclk);
    #1;
    chk("irq_masked", {31'h0, irq}, 32'h0);
    axi_write(ssi_pkg::OFS_IRQ_CLEAR, 32'h1);
    axi_read(ssi_pkg::OFS_IRQ_STATUS);
    chk("irq_cleared", {31'h0, rd[ssi_pkg::IRQ_GUARD_TRIP]}, 32'h0);
    axi_write(ssi_pkg::OFS_IRQ_ENABLE, 32'hF);
    @(posedge aclk);
    guard <= 1'b1;
    repeat (10) @(posedge aclk);
    #1;
    chk("guard_needs_ack", {31'h0, con_a}, 32'h0);
    ack_pulse();
    wait_con(1'b1);
    repeat (12) @(posedge aclk);
    $display("test guard done");
    @(posedge aclk);
    estop <= 1'b0;
    @(posedge aclk);
    #1;
    chk("estop_run", {31'h0, run_req}, 32'h0);
    chk("estop_hold", {31'h0, con_a}, 32'h1);
    wait_con(1'b0);
    chk("estop_delay", {31'h0, n >= sd && n <= sd + 4}, 32'h1);
    axi_read(ssi_pkg::OFS_IRQ_STATUS);
    chk("irq_estop", {31'h0, rd[ssi_pkg::IRQ_ESTOP_DONE]}, 32'h1);
    @(posedge aclk);
    estop <= 1'b1;
    repeat (10) @(posedge aclk);
    #1;
    chk("estop_needs_ack", {31'h0, con_a}, 32'h0);
    ack_pulse();
    wait_con(1'b1);
    repeat (12) @(posedge aclk);
    $display("test emergency stop done");
    @(posedge aclk);
    weld <= 1'b1;
    guard <= 1'b0;
    status_bit(ssi_pkg::ST_RB_ERROR, 1'b0);
    repeat (TMO + 8) @(posedge aclk);
    status_bit(ssi_pkg::ST_RB_ERROR, 1'b1);
    axi_read(ssi_pkg::OFS_IRQ_STATUS);
    chk("irq_rb_error", {31'h0, rd[ssi_pkg::IRQ_RB_ERROR]}, 32'h1);
    @(posedge aclk);
    guard <= 1'b1;
    ack_pulse();
    repeat (10) @(posedge aclk);
    #1;
    chk("error_blocks", {31'h0, con_a}, 32'h0);
    status_bit(ssi_pkg::ST_RB_ERROR, 1'b1);
    @(posedge aclk);
    weld <= 1'b0;
    repeat (8) @(posedge aclk);
    ack_pulse();
    wait_con(1'b1);
    chk("error_ack", {31'h0, n <= 6}, 32'h1);
    status_bit(ssi_pkg::ST_RB_ERROR, 1'b0);
    repeat (12) @(posedge aclk);
    $display("test readback done");
    @(posedge aclk);
    passivate <= 1'b1;
    @(posedge aclk);
    passivate <= 1'b0;
    @(posedge aclk);
    #1;
    chk("reinstate", {31'h0, reinstate}, 32'h1);
    repeat (10) @(posedge aclk);
    #1;
    chk("reinstated", {31'h0, passivated}, 32'h0);
    repeat (40) @(posedge aclk);
    status_bit(ssi_pkg::ST_RB_ERROR, 1'b0);
    chk("passive_no_ack", {31'h0, con_a}, 32'h1);
    $display("test passivation done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
